/* mcc_clock_ctrl.sv */
// Main clock source selection, prescaler, change protection and lock.
`timescale 1ns/1ns
`include "mcc_clock_defs.svh"
module mcc_clock_ctrl #(
  parameter logic [7:0]  KEY  = 8'h5a, // Arbitrary unlock value.
  parameter logic [16:0] X16K = 17'h04000,
  parameter logic [16:0] X32K = 17'h08000,
  parameter logic [16:0] X64K = 17'h10000
) (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        keyWrite,
  input  wire logic [7:0]  keyData,
  input  wire logic        instrRetire,
  input  wire logic        fastRcClk,
  input  wire logic        slowRcClk,
  input  wire logic        xtalCoreClk,
  input  wire logic        crystalPinIn,
  input  wire logic        extClockPin,
  input  wire logic        fuseCalLock,
  input  wire logic [3:0]  periphSrcReq,
  input  wire logic        sleepMode,
  input  wire logic        sysclkInUse,
  output logic             mainClk,
  output logic             perClk,
  output logic             sysclk_pin_output,
  output logic             crystalPinOverride,
  output logic             xtalRun,
  output logic             extPinConfig,
  output logic [5:0]       fastTrimA,
  output logic [3:0]       fastTrimB
);

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  logic [5:0]             syncA;
  logic [5:0]             syncB;
  logic [3:0]             srcLvl;
  logic [3:0]             lvlPrev;
  logic [3:0]             srcEdge;
  logic [3:0]             srcReq;
  logic [3:0]             srcRun;
  logic [3:0]             srcStable;
  logic [1:0]             srcSel;
  logic                   clkoutEn;
  logic                   prescale_enable;
  logic [3:0]             prescale_divider;
  logic                   lock_enable_bit;
  logic                   fastStby;
  logic                   slowStby;
  logic                   xEnable;
  logic                   xStby;
  logic                   xSel;
  logic [1:0]             xCsut;
  logic                   calLock;
  logic [2:0]             winCnt;
  logic                   winOpen;
  logic                   keyHit;
  logic [7:0]             awAddrQ;
  logic [7:0]             wByte;
  logic                   wStrb0;
  logic [4:0]             wIdx;
  logic                   wHit;
  logic                   doWr;
  logic                   protWr;
  logic                   wEn;
  logic [7:0]             rdMux;
  logic                   rdHit;
  logic                   mainPrev;
  logic [5:0]             divCnt;
  mcc_pkg::mcc_source_type activeSel;
  mcc_pkg::mcc_switch_type swState;

  // Map a register index onto whether it exists at all.
  function automatic logic isMapped(input logic [4:0] idx);
    case (idx)
      `MCC_IDX_SRC, `MCC_IDX_PRE, `MCC_IDX_LOCK, `MCC_IDX_STAT,
      `MCC_IDX_FCTL, `MCC_IDX_TRA, `MCC_IDX_TRB, `MCC_IDX_SCTL,
      `MCC_IDX_XCTL: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction : isMapped

  // Half of the division ratio; reserved codes fall back to division by two.
  function automatic logic [5:0] divHalf(input logic [3:0] code);
    case (code)
      4'h0: divHalf = 6'h01;
      4'h1: divHalf = 6'h02;
      4'h2: divHalf = 6'h04;
      4'h3: divHalf = 6'h08;
      4'h4: divHalf = 6'h10;
      4'h5: divHalf = 6'h20;
      4'h8: divHalf = 6'h03;
      4'h9: divHalf = 6'h05;
      4'ha: divHalf = 6'h06;
      4'hb: divHalf = 6'h0c;
      4'hc: divHalf = 6'h18;
      default: divHalf = 6'h01;
    endcase
  endfunction : divHalf

  // Oscillator edges a source needs before it counts as stable.
  function automatic logic [16:0] startTarget(input int idx);
    if (idx == 2) begin
      if (xSel) begin
        startTarget = `MCC_TWO_START;
      end else begin
        case (xCsut)
          2'h0:    startTarget = `MCC_X1K;
          2'h1:    startTarget = X16K;
          2'h2:    startTarget = X32K;
          default: startTarget = X64K;
        endcase
      end
    end else if (idx == 3) begin
      startTarget = `MCC_TWO_START;
    end else begin
      startTarget = `MCC_RC_START;
    end
  endfunction : startTarget

  // Oscillator and pin levels are asynchronous, so all pass two flip-flops first.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      syncA <= 6'h00;
      syncB <= 6'h00;
    end else begin
      syncA <= {fuseCalLock, extClockPin, crystalPinIn, xtalCoreClk, slowRcClk, fastRcClk};
      syncB <= syncA;
    end
  end

  // The crystal path takes the pin clock or the crystal core, per the type bit.
  assign srcLvl  = {syncB[4], xSel ? syncB[3] : syncB[2], syncB[1], syncB[0]};
  assign srcEdge = srcLvl & ~lvlPrev;

  // Previous source levels for rising edge detection.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lvlPrev <= 4'h0;
    end else begin
      lvlPrev <= srcLvl;
    end
  end

  // A source is requested by a peripheral, by the pending choice or as the running one.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      srcReq[i] = periphSrcReq[i] || (srcSel == 2'(i)) || (activeSel == 2'(i));
    end
    srcRun[0] = srcReq[0] || fastStby;
    srcRun[1] = srcReq[1] || slowStby;
    srcRun[2] = xEnable && (srcReq[2] || xStby);
    srcRun[3] = srcReq[3];
  end

  // Each source counts its own edges; status shows only while it is requested.
  genvar g;
  for (g = 0; g < 4; g++) begin : g_src
    logic [16:0] cnt;
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        cnt <= 17'h00000;
      end else if (!srcRun[g]) begin
        cnt <= 17'h00000;
      end else if (srcEdge[g] && cnt < startTarget(g)) begin
        cnt <= cnt + 17'h00001;
      end
    end
    assign srcStable[g] = srcRun[g] && srcReq[g] && (cnt >= startTarget(g));
  end

  chk_ext_two: assert property (srcStable[3] |-> g_src[3].cnt == 17'h00002)
    else $error("External clock ready before two edges.");
  chk_xtal_fixed: assert property (srcStable[2] && xSel |-> g_src[2].cnt == 17'h00002)
    else $error("Pin clock start-up is not two edges.");
  chk_xtal_crystal_startup_select: assert property (srcStable[2] && !xSel && xCsut == 2'h0 |-> g_src[2].cnt == 17'h00400)
    else $error("Crystal ready before its start-up count.");
  chk_xtal_gate: assert property (!xEnable |=> g_src[2].cnt == 17'h00000 && !srcStable[2])
    else $error("Crystal runs while disabled.");

  // Switch over only once the newly chosen source reports stable.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      swState   <= mcc_pkg::SW_IDLE;
      activeSel <= mcc_pkg::SRC_FAST;
    end else begin
      case (swState)
        mcc_pkg::SW_IDLE: begin
          if (srcSel != activeSel) begin
            swState <= mcc_pkg::SW_WAIT;
          end
        end
        mcc_pkg::SW_WAIT: begin
          if (srcSel == activeSel) begin
            swState <= mcc_pkg::SW_IDLE;
          end else if (srcStable[srcSel]) begin
            activeSel <= mcc_pkg::mcc_source_type'(srcSel);
            swState   <= mcc_pkg::SW_IDLE;
          end
        end
        default: swState <= mcc_pkg::SW_IDLE;
      endcase
    end
  end

  sequence seqReadyToSwitch;
    swState == mcc_pkg::SW_WAIT && srcSel != activeSel && srcStable[srcSel];
  endsequence
  chk_switch_done: assert property (seqReadyToSwitch |=> activeSel == $past(srcSel) && swState == mcc_pkg::SW_IDLE)
    else $error("Switch did not complete on a stable source.");

  // Main clock level, its edge history and the pin outputs.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mainClk            <= 1'b0;
      mainPrev           <= 1'b0;
      sysclk_pin_output             <= 1'b0;
      crystalPinOverride <= 1'b0;
      xtalRun            <= 1'b0;
      extPinConfig       <= 1'b0;
    end else begin
      mainClk            <= srcLvl[activeSel];
      mainPrev           <= mainClk;
      sysclk_pin_output             <= clkoutEn && (!sleepMode || sysclkInUse) && mainClk;
      crystalPinOverride <= xEnable;
      xtalRun            <= srcRun[2];
      extPinConfig       <= srcReq[3];
    end
  end

  chk_sysclk_pin_output_sleep: assert property (sleepMode && !sysclkInUse |=> !sysclk_pin_output)
    else $error("Clock output toggles in sleep.");
  chk_pin_override: assert property (xEnable |=> crystalPinOverride)
    else $error("Crystal pins not overridden.");
  chk_ext_pin: assert property (srcReq[3] |=> extPinConfig)
    else $error("External clock pin not configured.");

  // The comparison uses the divider live, so a run-time change takes effect cleanly.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      perClk <= 1'b0;
      divCnt <= 6'h00;
    end else if (!prescale_enable) begin
      perClk <= mainClk;
      divCnt <= 6'h00;
    end else if (mainClk && !mainPrev) begin
      if (divCnt >= divHalf(prescale_divider) - 6'h01) begin
        divCnt <= 6'h00;
        perClk <= !perClk;
      end else begin
        divCnt <= divCnt + 6'h01;
      end
    end
  end

  chk_pen_off: assert property (!prescale_enable |=> perClk == $past(mainClk))
    else $error("Undivided clock does not follow the main clock.");

  // Unlock window, counted down in retired instructions.
  assign keyHit  = keyWrite && (keyData == KEY);
  assign winOpen = (winCnt != 3'h0);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      winCnt <= 3'h0;
    end else if (keyHit) begin
      winCnt <= `MCC_WIN_INSTR;
    end else if (protWr) begin
      winCnt <= 3'h0;
    end else if (instrRetire && winOpen) begin
      winCnt <= winCnt - 3'h1;
    end
  end

  sequence seqLastInstr;
    winCnt == 3'h1 && instrRetire && !keyHit;
  endsequence
  chk_window_close: assert property (seqLastInstr |=> !winOpen)
    else $error("Unlock window outlived four instructions.");
  chk_key_open: assert property (keyHit |=> winCnt == 3'h4)
    else $error("Key did not open the window.");

  // Address and data channels are taken in either order and held until the response.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      awAddrQ       <= 8'h00;
      wByte         <= 8'h00;
      wStrb0        <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awAddrQ       <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wByte        <= s_axi_wdata[7:0];
        wStrb0       <= s_axi_wstrb[0];
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Every register but status needs an open window; a refused write still answers OKAY.
  assign wIdx    = awAddrQ[6:2];
  assign wHit    = !awAddrQ[7] && isMapped(wIdx);
  assign doWr    = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign protWr  = doWr && wHit && (wIdx != `MCC_IDX_STAT);
  assign wEn     = protWr && wStrb0 && winOpen;
  assign calLock = syncB[5] || (lock_enable_bit && activeSel == mcc_pkg::SRC_FAST);

  // Write response.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `MCC_RESP_OK;
    end else if (doWr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wHit ? `MCC_RESP_OK : `MCC_RESP_ERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Source, prescaler and lock; the lock only clears by hardware reset.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      srcSel   <= 2'(`MCC_RST_SRC);
      clkoutEn <= 1'(`MCC_RST_SRC >> `MCC_SYSCLK_PIN_OUTPUT_BIT);
      prescale_enable      <= 1'(`MCC_RST_PRE);
      prescale_divider     <= 4'(`MCC_RST_PRE >> 1);
      lock_enable_bit   <= 1'b0;
    end else if (wEn && !lock_enable_bit) begin
      case (wIdx)
        `MCC_IDX_SRC: begin
          srcSel   <= wByte[1:0];
          clkoutEn <= wByte[`MCC_SYSCLK_PIN_OUTPUT_BIT];
        end
        `MCC_IDX_PRE: begin
          prescale_enable  <= wByte[0];
          prescale_divider <= wByte[4:1];
        end
        `MCC_IDX_LOCK: lock_enable_bit <= wByte[0];
        default: ;
      endcase
    end
  end

  sequence seqLocked;
    lock_enable_bit ##1 lock_enable_bit;
  endsequence
  chk_lock_hold: assert property (lock_enable_bit |=> seqLocked and ($stable(srcSel) && $stable(prescale_divider) && $stable(prescale_enable)))
    else $error("Locked settings changed.");
  chk_unprot_write: assert property (doWr && !winOpen |=> $stable(srcSel) && $stable(prescale_divider) && $stable(xEnable))
    else $error("Write outside the window changed a register.");

  // Fast oscillator trims, frozen by fuse or by lock while it drives the main clock.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fastTrimA <= `MCC_RST_TRA;
      fastTrimB <= `MCC_RST_TRB;
    end else if (wEn && !calLock) begin
      if (wIdx == `MCC_IDX_TRA) begin
        fastTrimA <= wByte[5:0];
      end
      if (wIdx == `MCC_IDX_TRB) begin
        fastTrimB <= wByte[3:0];
      end
    end
  end

  // Oscillator controls; the crystal type and start-up only change while it is stopped.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fastStby <= 1'b0;
      slowStby <= 1'b0;
      xEnable  <= 1'b0;
      xStby    <= 1'b0;
      xSel     <= 1'b0;
      xCsut    <= 2'h0;
    end else if (wEn) begin
      case (wIdx)
        `MCC_IDX_FCTL: fastStby <= wByte[`MCC_STBY_BIT];
        `MCC_IDX_SCTL: slowStby <= wByte[`MCC_STBY_BIT];
        `MCC_IDX_XCTL: begin
          xEnable <= wByte[0];
          xStby   <= wByte[`MCC_STBY_BIT];
          if (!xEnable && !srcStable[2]) begin
            xSel  <= wByte[2];
            xCsut <= wByte[5:4];
          end
        end
        default: ;
      endcase
    end
  end

  // Read data selection; reserved bits read zero.
  always_comb begin
    rdHit = !s_axi_araddr[7] && isMapped(s_axi_araddr[6:2]);
    case (s_axi_araddr[6:2])
      `MCC_IDX_SRC:  rdMux = {clkoutEn, 5'h00, srcSel};
      `MCC_IDX_PRE:  rdMux = {3'h0, prescale_divider, prescale_enable};
      `MCC_IDX_LOCK: rdMux = {7'h00, lock_enable_bit};
      `MCC_IDX_STAT: rdMux = {srcStable[3], srcStable[2], srcStable[1], srcStable[0], 3'h0,
                              swState == mcc_pkg::SW_WAIT};
      `MCC_IDX_FCTL: rdMux = {6'h00, fastStby, 1'b0};
      `MCC_IDX_TRA:  rdMux = {2'h0, fastTrimA};
      `MCC_IDX_TRB:  rdMux = {syncB[5], 3'h0, fastTrimB};
      `MCC_IDX_SCTL: rdMux = {6'h00, slowStby, 1'b0};
      `MCC_IDX_XCTL: rdMux = {2'h0, xCsut, 1'b0, xSel, xStby, xEnable};
      default:       rdMux = 8'h00;
    endcase
    if (s_axi_araddr[7]) begin
      rdMux = 8'h00;
    end
  end

  // Read channel, one outstanding read.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `MCC_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, rdMux};
      s_axi_rresp   <= rdHit ? `MCC_RESP_OK : `MCC_RESP_ERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : mcc_clock_ctrl

/* mcc_clock_defs.svh */
// Offsets, field positions, reset values and start-up counts of the main clock controller.
// Function
// - Crystal input comes from crystal pins or external clock pin, per source type bit.
// - Crystal enable set hands the two oscillator pins over to oscillator duty.
// - Crystal oscillator runs on request only while its enable bit is set.
// - Crystal start-up delay is taken from the start-up select field.
// - With external clock on the crystal input, start-up is fixed at two cycles.
// - Any request for the external clock input configures its pin as clock input.
// - External clock input becomes usable two cycles after first request.
// - Protected write needs unlock key first, then write within four instructions.
// - Protected write outside the window completes without error, contents unchanged.
// - All registers except status are protected by the same register key.
// - Clock output bit 7 of source select drives system clock onto output pin.
// - In sleep the clock output carries no clock unless a peripheral uses it.
// - Source field: 0 fast RC, 1 slow RC, 2 crystal, 3 external clock.
// - Divider codes 0-5 give 2..64, codes 8-C give 6,10,12,24,48.
// - Divider field may be rewritten at run time, changing peripheral clock live.
// - Prescaler disabled passes the main clock undivided, whatever the divider holds.
// - Lock bit blocks updates to source, prescaler and current source calibration.
// - Once locked, the lock register stays locked until the next hardware reset.
// - After reset the main clock is fast RC with prescaler dividing by six.
// - Start-up select codes 0-3 give 1k, 16k, 32k, 64k oscillator cycles.
// - Switching flag reads one until the new source is stable and taken over.
`ifndef MCC_CLOCK_DEFS_SVH
`define MCC_CLOCK_DEFS_SVH
`define MCC_IDX_SRC   5'h00
`define MCC_IDX_PRE   5'h01
`define MCC_IDX_LOCK  5'h02
`define MCC_IDX_STAT  5'h03
`define MCC_IDX_FCTL  5'h10
`define MCC_IDX_TRA   5'h11
`define MCC_IDX_TRB   5'h12
`define MCC_IDX_SCTL  5'h18
`define MCC_IDX_XCTL  5'h1c
`define MCC_SYSCLK_PIN_OUTPUT_BIT 7
`define MCC_STBY_BIT   1
`define MCC_RST_SRC   8'h00
`define MCC_RST_PRE   8'h11
`define MCC_RST_TRA   6'h20
`define MCC_RST_TRB   4'h8
`define MCC_RC_START  17'h00004
`define MCC_TWO_START 17'h00002
`define MCC_X1K       17'h00400
`define MCC_WIN_INSTR 3'h4
`define MCC_RESP_OK   2'h0
`define MCC_RESP_ERR  2'h2
`endif

/* mcc_pkg.sv */
// Types shared by the main clock controller.
package mcc_pkg;
  typedef enum logic [1:0] {
    SRC_FAST = 2'h0,
    SRC_SLOW = 2'h1,
    SRC_XTAL = 2'h2,
    SRC_EXT  = 2'h3
  } mcc_source_type;
  typedef enum logic [1:0] {
    SW_IDLE = 2'b01,
    SW_WAIT = 2'b10
  } mcc_switch_type;
endpackage : mcc_pkg

/* mcc_clock_ctrl_tb_top.sv */
// Self-checking testbench of the main clock controller: registers, protection, sources, prescaler and lock.
`timescale 1ns/1ns
module mcc_clock_ctrl_tb_top;
  localparam logic [7:0] KEY = 8'h5a; // Arbitrary unlock value.
  logic        clock = 1'b0, arst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic        keyWrite = 1'b0, instrRetire = 1'b0, sleepMode = 1'b0, sysclkInUse = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, keyData = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0]  periphSrcReq = 4'h0, extCnt = 4'h0;
  logic [4:0]  cnt = 5'h00;
  logic        awready, wready, bvalid, arready, rvalid, mainClk, perClk, sysclk_pin_output, crystalPinOverride;
  logic        xtalRun, extPinConfig;
  logic        bready = 1'b0, rready = 1'b0;
  logic [1:0]  bresp, rresp, rr;
  logic [31:0] rdata;
  logic [5:0]  fastTrimA;
  logic [3:0]  fastTrimB;
  int          nFail = 0, nTests = 0, cycles = 0;

  mcc_clock_ctrl #(.KEY(KEY), .X16K(17'h00010), .X32K(17'h00020), .X64K(17'h00040)) i_dut (
    .clock(clock), .arst_n(arst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .keyWrite(keyWrite), .keyData(keyData), .instrRetire(instrRetire), .fastRcClk(cnt[2]), .slowRcClk(cnt[3]),
    .xtalCoreClk(cnt[1]), .crystalPinIn(cnt[4]), .extClockPin(extCnt > 4'h5), .fuseCalLock(1'b0),
    .periphSrcReq(periphSrcReq), .sleepMode(sleepMode), .sysclkInUse(sysclkInUse), .mainClk(mainClk),
    .perClk(perClk), .sysclk_pin_output(sysclk_pin_output), .crystalPinOverride(crystalPinOverride), .xtalRun(xtalRun),
    .extPinConfig(extPinConfig), .fastTrimA(fastTrimA), .fastTrimB(fastTrimB));

  always #50 clock = ~clock;

  // Oscillators run well below the system clock so that the synchronisers see every edge.
  always @(posedge clock) begin
    cnt <= cnt + 5'h01;
    extCnt <= (extCnt == 4'hb) ? 4'h0 : extCnt + 4'h1;
  end

  // A hung handshake ends the run here rather than stalling forever.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      nFail++;
      wrapUp();
    end
  end

  task automatic wrapUp;
    if (nFail == 0 && nTests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrapUp

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    nTests++;
    if (g !== e) begin
      nFail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  // Address and data are offered together and each is dropped once taken.
  // No per-call limit: a missing answer runs into the cycle ceiling and fails the run there.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    r = 2'h1;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!done) begin
      @(posedge clock);
      if ((awvalid && awready) || (wvalid && wready)) bready <= 1'b1;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1 && bready) begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : wr

  // The response ready rises once the address is taken, so back-to-back reads never toggle it in one step.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic done;
    done = 1'b0;
    d = 8'hxx;
    araddr <= a;
    arvalid <= 1'b1;
    while (!done) begin
      @(posedge clock);
      if (rvalid === 1'b1 && rready) begin
        d = rdata[7:0];
        rr = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        rready <= 1'b1;
      end
    end
  endtask : rd

  task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    cmp(nm, {24'h000000, e}, {24'h000000, v});
  endtask : rc

  task automatic unlock;
    keyWrite <= 1'b1;
    keyData <= KEY;
    @(posedge clock);
    keyWrite <= 1'b0;
  endtask : unlock

  task automatic pw(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    unlock();
    wr(a, d, r);
  endtask : pw

  // Cycles of one peripheral clock period, and main clock rises inside it.
  task automatic measure(output int cyc, output int mr);
    logic pm, pp;
    int k;
    cyc = 0;
    mr = 0;
    k = 0;
    pm = mainClk;
    pp = perClk;
    while (k < 2 && cyc < 4000) begin
      @(posedge clock);
      if (mainClk && !pm && k == 1) mr++;
      if (perClk && !pp) k++;
      if (k == 1) cyc++;
      pm = mainClk;
      pp = perClk;
    end
  endtask : measure

  // Status is polled with a short bound, so a slow start-up shows up as a mismatch.
  task automatic poll(input int b, input logic v, output logic [7:0] d);
    int n;
    n = 0;
    do begin
      rd(8'h0c, d);
      n++;
    end while (d[b] !== v && n < 40);
  endtask : poll

  task automatic rises(output int n);
    logic p;
    n = 0;
    repeat (4) @(posedge clock);
    p = sysclk_pin_output;
    repeat (40) begin
      @(posedge clock);
      if (sysclk_pin_output && !p) n++;
      p = sysclk_pin_output;
    end
  endtask : rises

  initial begin
    int c, m;
    int codes[11] = '{0, 1, 2, 3, 4, 5, 8, 9, 10, 11, 12};
    int ratios[11] = '{2, 4, 8, 16, 32, 64, 6, 10, 12, 24, 48};
    int srcs[3] = '{1, 3, 2};
    int pers[3] = '{16, 12, 32};
    logic [1:0] r;
    logic [7:0] d;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    rc("source", 8'h00, 8'h00);
    rc("prescaler", 8'h04, 8'h11);
    rc("lock", 8'h08, 8'h00);
    measure(c, m);
    measure(c, m);
    cmp("reset ratio", 6, m);
    wr(8'h04, 8'h00, r);
    cmp("bresp", 2'h0, r);
    rc("prescaler", 8'h04, 8'h11);
    unlock();
    instrRetire <= 1'b1;
    repeat (4) @(posedge clock);
    instrRetire <= 1'b0;
    wr(8'h04, 8'h00, r);
    rc("prescaler", 8'h04, 8'h11);
    pw(8'h04, 8'h18, r);
    rc("prescaler", 8'h04, 8'h18);
    wr(8'h04, 8'h03, r);
    rc("prescaler", 8'h04, 8'h18);
    measure(c, m);
    measure(c, m);
    cmp("undivided period", 8, c);
    // Each of the eleven divider codes 0-5 and 8-C is rewritten live; the first period after a change is discarded.
    for (int i = 0; i < 11; i++) begin
      pw(8'h04, {3'h0, codes[i][3:0], 1'b1}, r);
      measure(c, m);
      measure(c, m);
      cmp("divider ratio", ratios[i], m);
    end
    wr(8'h50, 8'h00, r);
    cmp("unmapped bresp", 2'h2, r);
    rd(8'h50, d);
    cmp("unmapped rresp", 2'h2, rr);
    cmp("unmapped rdata", 8'h00, d);
    pw(8'h44, 8'h15, r);
    rc("trim a", 8'h44, 8'h15);
    cmp("trim a pins", 6'h15, fastTrimA);
    pw(8'h48, 8'h0b, r);
    rc("trim b", 8'h48, 8'h0b);
    cmp("trim b pins", 4'hb, fastTrimB);
    pw(8'h70, 8'h04, r);
    periphSrcReq <= 4'h4;
    repeat (4) @(posedge clock);
    cmp("crystal run", 1'b0, xtalRun);
    cmp("crystal pins", 1'b0, crystalPinOverride);
    pw(8'h70, 8'h05, r);
    repeat (4) @(posedge clock);
    cmp("crystal pins", 1'b1, crystalPinOverride);
    cmp("crystal run", 1'b1, xtalRun);
    poll(6, 1'b1, d);
    cmp("crystal stable", 1'b1, d[6]);
    periphSrcReq <= 4'h8;
    repeat (4) @(posedge clock);
    cmp("ext pin", 1'b1, extPinConfig);
    poll(7, 1'b1, d);
    cmp("ext stable", 1'b1, d[7]);
    periphSrcReq <= 4'h0;
    pw(8'h04, 8'h00, r);
    for (int i = 0; i < 3; i++) begin
      pw(8'h00, srcs[i][7:0], r);
      rd(8'h0c, d);
      if (i == 0) cmp("switching", 1'b1, d[0]);
      poll(0, 1'b0, d);
      measure(c, m);
      measure(c, m);
      cmp("source period", pers[i], c);
    end
    pw(8'h00, 8'h80, r);
    poll(0, 1'b0, d);
    rises(c);
    cmp("clock out", 5, c);
    sleepMode <= 1'b1;
    rises(c);
    cmp("clock out sleep", 0, c);
    sysclkInUse <= 1'b1;
    rises(c);
    cmp("clock out in use", 5, c);
    // Crystal core path with start-up select code 0 (1k edges, the longest here): not stable early, stable once the count has run.
    pw(8'h70, 8'h00, r);
    pw(8'h70, 8'h01, r);
    rc("crystal ctrl", 8'h70, 8'h01);
    periphSrcReq <= 4'h4;
    repeat (1000) @(posedge clock);
    rc("crystal early", 8'h0c, 8'h10);
    repeat (3200) @(posedge clock);
    rc("crystal started", 8'h0c, 8'h50);
    pw(8'h08, 8'h01, r);
    rc("lock", 8'h08, 8'h01);
    pw(8'h44, 8'h2a, r);
    rc("trim a locked", 8'h44, 8'h15);
    pw(8'h00, 8'h01, r);
    rc("source", 8'h00, 8'h80);
    pw(8'h04, 8'h03, r);
    rc("prescaler", 8'h04, 8'h00);
    pw(8'h08, 8'h00, r);
    rc("lock", 8'h08, 8'h01);
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    rc("lock", 8'h08, 8'h00);
    rc("source", 8'h00, 8'h00);
    wrapUp();
  end
endmodule : mcc_clock_ctrl_tb_top
